// >>> src/plcad_pkg.sv
package plcad_pkg;
    // ==========================================================
    // action codes
    localparam logic [5:0] ACT_DRIVE_EN  = 6'h04;
    localparam logic [5:0] ACT_JOG_REV   = 6'h05;
    localparam logic [5:0] ACT_JOG_FWD   = 6'h06;
    localparam logic [5:0] ACT_RSV_HOLD  = 6'h07;
    localparam logic [5:0] ACT_STOP      = 6'h08;
    localparam logic [5:0] ACT_RSV_LO    = 6'h09;
    localparam logic [5:0] ACT_RSV_HI    = 6'h0c;
    localparam logic [5:0] ACT_JOG_EN    = 6'h12;
    localparam logic [5:0] ACT_FAULT     = 6'h13;
    localparam logic [5:0] ACT_PRESET    = 6'h18;
    localparam logic [5:0] ACT_PIDX0     = 6'h19;
    localparam logic [5:0] ACT_PID       = 6'h1d;
    localparam logic [5:0] ACT_KEYPAD    = 6'h1e;
    localparam logic [5:0] ACT_EPOT      = 6'h1f;
    localparam logic [5:0] ACT_EPOT_UP   = 6'h20;
    localparam logic [5:0] ACT_EPOT_DN   = 6'h21;
    localparam logic [5:0] ACT_TBL_EN    = 6'h22;
    localparam logic [5:0] ACT_TIDX0     = 6'h23;
    localparam logic [5:0] ACT_TIDX1     = 6'h24;
    localparam int         NUM_ACT       = 64;

    // ==========================================================
    // widths and table sizes
    localparam int         SPD_W         = 16;
    localparam int         NUM_PRESET    = 15;
    localparam logic [3:0] PIDX_ZERO     = 4'hf;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_FLAGS     = 8'h04;
    localparam logic [7:0] OFS_JOGSPD    = 8'h08;
    localparam logic [7:0] OFS_EPSTEP    = 8'h0c;
    localparam logic [7:0] OFS_EPOT      = 8'h10;
    localparam logic [7:0] OFS_CMDSRC    = 8'h14;
    localparam logic [7:0] OFS_PRESET0   = 8'h40;

    // ==========================================================
    // reset values
    localparam logic [SPD_W-1:0] RST_JOGSPD = 16'h0000;
    localparam logic [SPD_W-1:0] RST_EPSTEP = 16'h0001;
    localparam logic [SPD_W-1:0] RST_SPEED  = 16'h0000;
    localparam logic [1:0]       RST_CMDSRC = 2'h0;
    localparam logic [1:0]       RST_TABLE  = 2'h0;

    // ==========================================================
    // speed reference source
    typedef enum logic [1:0] {
        SRC_COMMAND,
        SRC_PRESET,
        SRC_EPOT,
        SRC_KEYPAD
    } plcad_src_t;
endpackage

// >>> src/plcad_action_decoder.sv
// Our own choices: the Wishbone register port and the placing of the registers.
module plcad_action_decoder
    import plcad_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    // condition evaluator side
    input  wire logic             actValid,
    input  wire logic [5:0]       actCode,
    input  wire logic             actCond,
    input  wire logic             scanEnd,
    // external references
    input  wire logic             hardwareEnableIn,
    input  wire logic [SPD_W-1:0] cmdSourceRef,
    input  wire logic [SPD_W-1:0] keypadRef,
    input  wire logic             keypadFwd,
    input  wire logic             keypadRev,
    input  wire logic             keypadStop,
    // motor control core side
    output logic                  driveEnable,
    output logic                  runFwd,
    output logic                  runRev,
    output logic                  stopCmd,
    output logic                  jogActive,
    output logic                  plcFault,
    output logic                  pidEnable,
    output logic                  keypadControl,
    output logic [1:0]            refSource,
    output logic [3:0]            presetIndex,
    output logic [SPD_W-1:0]      speedRef,
    output logic                  tableSwitchEn,
    output logic [1:0]            activeTableSetting,
    output logic [1:0]            commandSourceSelect,
    // wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o
);

    // ==========================================================
    // scan accumulation
    logic [NUM_ACT-1:0] seenAcc_r;
    logic [NUM_ACT-1:0] condAcc_r;
    logic [NUM_ACT-1:0] seenNow;
    logic [NUM_ACT-1:0] condNow;
    logic [NUM_ACT-1:0] assigned_r;
    logic [NUM_ACT-1:0] cond_r;
    logic               scanDone_r;

    // per-code view of the current cycle's report folded into the scan
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ACT; gi++) begin : gAct
            assign seenNow[gi] = seenAcc_r[gi]
                | (actValid && actCode == 6'(gi));
            assign condNow[gi] = condAcc_r[gi]
                | (actValid && actCode == 6'(gi) && actCond);
        end
    endgenerate

    // several rules may share one code; any true one makes it true
    always_ff @(posedge mclk) begin
        if (rst || scanEnd) begin
            seenAcc_r <= '0;
            condAcc_r <= '0;
        end else begin
            seenAcc_r <= seenNow;
            condAcc_r <= condNow;
        end
    end

    // commit a whole scan at once so outputs never see a half scan
    always_ff @(posedge mclk) begin
        if (rst) begin
            assigned_r <= '0;
            cond_r     <= '0;
            scanDone_r <= 1'b0;
        end else begin
            scanDone_r <= scanEnd;
            if (scanEnd) begin
                assigned_r <= seenNow;
                cond_r     <= condNow;
            end
        end
    end

    // unassigned codes read false through the seen mask
    function automatic logic act(input logic [5:0] code);
        act = assigned_r[code] && cond_r[code];
    endfunction

    // level view of every code for continuous logic; a function call in an
    // assign would not wake up when a new scan is committed
    logic [NUM_ACT-1:0] actOn;
    assign actOn = assigned_r & cond_r;

    // ==========================================================
    // registers
    logic [SPD_W-1:0] jogSpeed_r;
    logic [SPD_W-1:0] epotStep_r;
    logic [SPD_W-1:0] epot_r;
    logic [1:0]       cmdSrc_r;
    logic             rsvSeen_r;
    logic [SPD_W-1:0] preset_r [NUM_PRESET];
    logic             wbHit;
    logic             wbWr;
    logic [31:0]      rdData;
    logic [3:0]       presetSlot;
    logic             presetHit;

    assign wbHit      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr       = wbHit && wb_we_i;
    assign presetSlot = 4'((wb_adr_i - OFS_PRESET0) >> 2);
    // the upper bound stops words above the table aliasing onto low slots
    assign presetHit  = wb_adr_i >= OFS_PRESET0 && wb_adr_i[1:0] == 2'h0
        && wb_adr_i < OFS_PRESET0 + 8'(4 * NUM_PRESET)
        && presetSlot < 4'(NUM_PRESET);

    // byte-lane merge of a 16-bit field
    function automatic logic [SPD_W-1:0] merge16(
        input logic [SPD_W-1:0] old,
        input logic [31:0]      d,
        input logic [3:0]       s
    );
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // single-cycle answer, dropped in the cycle after
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= wbHit ? rdData : 32'h0;
        end
    end

    // software-written settings
    always_ff @(posedge mclk) begin
        if (rst) begin
            jogSpeed_r <= RST_JOGSPD;
            epotStep_r <= RST_EPSTEP;
            cmdSrc_r   <= RST_CMDSRC;
        end else if (wbWr) begin
            if (wb_adr_i == OFS_JOGSPD) begin
                jogSpeed_r <= merge16(jogSpeed_r, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFS_EPSTEP) begin
                epotStep_r <= merge16(epotStep_r, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFS_CMDSRC && wb_sel_i[0]) begin
                cmdSrc_r <= wb_dat_i[1:0];
            end
        end
    end

    // preset table has no reset; software loads it before use
    always_ff @(posedge mclk) begin
        if (wbWr && presetHit) begin
            preset_r[presetSlot] <= merge16(preset_r[presetSlot], wb_dat_i, wb_sel_i);
        end
    end

    // reserved code seen: sticky, write one to clear, a new hit wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsvSeen_r <= 1'b0;
        end else if (actValid && (actCode == ACT_RSV_HOLD
                || (actCode >= ACT_RSV_LO && actCode <= ACT_RSV_HI))) begin
            rsvSeen_r <= 1'b1;
        end else if (wbWr && wb_adr_i == OFS_FLAGS && wb_sel_i[0] && wb_dat_i[0]) begin
            rsvSeen_r <= 1'b0;
        end
    end

    // read mux; unmapped words answer zero
    always_comb begin
        rdData = 32'h0;
        case (wb_adr_i)
            OFS_STATUS: rdData = {12'h0, presetIndex, activeTableSetting, refSource,
                tableSwitchEn, keypadControl, pidEnable, plcFault, jogActive,
                stopCmd, runRev, runFwd, driveEnable, hardwareEnableIn,
                cmdSrc_r == RST_CMDSRC, scanDone_r};
            OFS_FLAGS:  rdData = {31'h0, rsvSeen_r};
            OFS_JOGSPD: rdData = {16'h0, jogSpeed_r};
            OFS_EPSTEP: rdData = {16'h0, epotStep_r};
            OFS_EPOT:   rdData = {16'h0, epot_r};
            OFS_CMDSRC: rdData = {30'h0, cmdSrc_r};
            default: begin
                if (presetHit) begin
                    rdData = {16'h0, preset_r[presetSlot]};
                end
            end
        endcase
    end

    // ==========================================================
    // electronic pot: unsigned, held through reset to act as retained
    logic [SPD_W:0] epotUp;
    logic           epotDnOk;

    assign epotUp   = {1'b0, epot_r} + {1'b0, epotStep_r};
    assign epotDnOk = epot_r >= epotStep_r;

    // steps once per scan; saturates instead of wrapping, no sign kept
    always_ff @(posedge mclk) begin
        if (wbWr && wb_adr_i == OFS_EPOT) begin
            epot_r <= merge16(epot_r, wb_dat_i, wb_sel_i);
        end else if (scanDone_r) begin
            if (act(ACT_EPOT_UP) && !act(ACT_EPOT_DN)) begin
                epot_r <= epotUp[SPD_W] ? '1 : epotUp[SPD_W-1:0];
            end else if (act(ACT_EPOT_DN) && !act(ACT_EPOT_UP)) begin
                epot_r <= epotDnOk ? epot_r - epotStep_r : '0;
            end
        end
    end

    // ==========================================================
    // decoded control
    logic             jogPermit;
    logic             jogF;
    logic             jogR;
    logic             jogBoth;
    logic             kpd;
    logic [3:0]       pIdx;
    plcad_src_t       src;
    logic [SPD_W-1:0] presetRef;
    logic [SPD_W-1:0] refNxt;

    assign jogPermit = actOn[ACT_JOG_EN];
    assign jogF      = jogPermit && actOn[ACT_JOG_FWD];
    assign jogR      = jogPermit && actOn[ACT_JOG_REV];
    assign jogBoth   = jogF && jogR;
    assign kpd       = actOn[ACT_KEYPAD];

    // unassigned bits are zero, so no bits gives the first preset
    generate
        for (gi = 0; gi < 4; gi++) begin : gPidx
            assign pIdx[gi] = actOn[ACT_PIDX0 + 6'(gi)];
        end
    endgenerate

    // index 15 holds no preset and means zero speed
    assign presetRef = (pIdx == PIDX_ZERO) ? RST_SPEED : preset_r[pIdx];

    // keypad outranks pot, pot outranks presets
    always_comb begin
        src = SRC_COMMAND;
        if (kpd) begin
            src = SRC_KEYPAD;
        end else if (actOn[ACT_EPOT]) begin
            src = SRC_EPOT;
        end else if (actOn[ACT_PRESET]) begin
            src = SRC_PRESET;
        end
    end

    // jog speed overrides any source while a single jog runs
    always_comb begin
        refNxt = cmdSourceRef;
        if (jogF ^ jogR) begin
            refNxt = jogSpeed_r;
        end else begin
            case (src)
                SRC_COMMAND: refNxt = cmdSourceRef;
                SRC_PRESET:  refNxt = presetRef;
                SRC_EPOT:    refNxt = epot_r;
                SRC_KEYPAD:  refNxt = keypadRef;
                default:     refNxt = cmdSourceRef;
            endcase
        end
    end

    // ==========================================================
    // drive enable and motion outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            driveEnable <= 1'b0;
        end else begin
            driveEnable <= hardwareEnableIn
                && (!assigned_r[ACT_DRIVE_EN] || cond_r[ACT_DRIVE_EN]);
        end
    end

    // direction comes from jog or keypad; pot carries no sign
    always_ff @(posedge mclk) begin
        if (rst) begin
            runFwd    <= 1'b0;
            runRev    <= 1'b0;
            stopCmd   <= 1'b0;
            jogActive <= 1'b0;
        end else begin
            runFwd    <= (jogF && !jogR)
                || (!jogF && !jogR && kpd && keypadFwd && !keypadRev);
            runRev    <= (jogR && !jogF)
                || (!jogF && !jogR && kpd && keypadRev && !keypadFwd);
            stopCmd   <= act(ACT_STOP)
                || jogBoth
                || (kpd && keypadStop);
            jogActive <= jogF ^ jogR; // two jogs mean stop, not jogging
        end
    end

    // fault is level; the core's fault handling latches it
    always_ff @(posedge mclk) begin
        if (rst) begin
            plcFault <= 1'b0;
        end else begin
            plcFault <= act(ACT_FAULT);
        end
    end

    // pid is dropped under keypad or jog whatever its own condition
    always_ff @(posedge mclk) begin
        if (rst) begin
            pidEnable     <= 1'b0;
            keypadControl <= 1'b0;
        end else begin
            pidEnable     <= act(ACT_PID) && !kpd && !(jogF || jogR);
            keypadControl <= kpd;
        end
    end

    // reference selection and value
    always_ff @(posedge mclk) begin
        if (rst) begin
            refSource   <= SRC_COMMAND;
            presetIndex <= '0;
            speedRef    <= RST_SPEED;
        end else begin
            refSource   <= src;
            presetIndex <= pIdx;
            speedRef    <= refNxt;
        end
    end

    // ==========================================================
    // parameter table: index held while switching is inhibited
    always_ff @(posedge mclk) begin
        if (rst) begin
            tableSwitchEn      <= 1'b0;
            activeTableSetting <= RST_TABLE;
        end else begin
            tableSwitchEn <= act(ACT_TBL_EN);
            if (act(ACT_TBL_EN)) begin
                activeTableSetting <= {act(ACT_TIDX1),
                    act(ACT_TIDX0)};
            end
        end
    end

    // command source choice is software-owned
    always_ff @(posedge mclk) begin
        if (rst) begin
            commandSourceSelect <= RST_CMDSRC;
        end else begin
            commandSourceSelect <= cmdSrc_r;
        end
    end

endmodule // plcad_action_decoder

// >>> dv/plcad_action_decoder_properties.sv
module plcad_action_decoder_properties
    import plcad_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        scanEnd,
    input wire logic        hardwareEnableIn,
    input wire logic        driveEnable,
    input wire logic        runFwd,
    input wire logic        runRev,
    input wire logic        jogActive,
    input wire logic        pidEnable,
    input wire logic        plcFault,
    input wire logic        keypadControl,
    input wire logic [1:0]  refSource,
    input wire logic [3:0]  presetIndex,
    input wire logic        tableSwitchEn,
    input wire logic [1:0]  activeTableSetting
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // register bus handshake
    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sAckPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_one_pulse: assert property (sReq |=> sAckPulse)
        else $error("bus ack not a one-cycle answer");
    chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");

    // ==========================================================
    // decoded outputs
    chk_enable_needs_hw: assert property (driveEnable |-> $past(hardwareEnableIn))
        else $error("drive enabled without hardware enable");
    chk_no_both_dirs: assert property (!(runFwd && runRev))
        else $error("both directions commanded");
    chk_jog_single_dir: assert property (jogActive |-> runFwd != runRev)
        else $error("jog running without one direction");
    chk_pid_forced_off: assert property ((keypadControl || jogActive) |-> !pidEnable)
        else $error("pid active under keypad or jog");
    chk_keypad_source: assert property (keypadControl |-> refSource == SRC_KEYPAD)
        else $error("keypad control without keypad reference");
    chk_commit_edge: assert property (($changed(presetIndex) || $changed(plcFault)
        || $changed(keypadControl)) |-> $past(scanEnd, 2))
        else $error("decoded output changed outside a commit");
    chk_table_gated: assert property ($changed(activeTableSetting) |-> tableSwitchEn)
        else $error("table changed while switching inhibited");
endmodule // plcad_action_decoder_properties

// >>> dv/plcad_ref_model.sv
// reference selectors of the control core: static command and keypad references
module plcad_ref_model
    import plcad_pkg::*;
#(
    parameter logic [SPD_W-1:0] CMD_REF = 16'h0abc,
    parameter logic [SPD_W-1:0] KPD_REF = 16'h0def
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    output logic [SPD_W-1:0]      cmdSourceRef,
    output logic [SPD_W-1:0]      keypadRef
);
    timeunit 1ns;
    timeprecision 100ps;
    // references drop to zero in reset, like a selector that is not yet set up
    always_ff @(posedge mclk) begin
        cmdSourceRef <= rst ? 16'h0000 : CMD_REF;
        keypadRef    <= rst ? 16'h0000 : KPD_REF;
    end
endmodule // plcad_ref_model

// >>> dv/test_plc_action_decoder.sv
`define CHECK_EQ(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module test_plc_action_decoder
    import plcad_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] CMD_REF = 16'h0abc;
    localparam logic [15:0] KPD_REF = 16'h0def;
    logic mclk, rst, actValid, actCond, scanEnd, hardwareEnableIn;
    logic keypadFwd, keypadRev, keypadStop, driveEnable, runFwd, runRev, stopCmd;
    logic jogActive, plcFault, pidEnable, keypadControl, tableSwitchEn;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0]  actCode;
    logic [15:0] cmdSourceRef, keypadRef, speedRef;
    logic [1:0]  refSource, activeTableSetting, commandSourceSelect;
    logic [3:0]  presetIndex, wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [5:0]  qCode[$];
    logic        qCond[$];
    int          n_mismatch = 0;
    int          n_compared = 0;

    plcad_action_decoder dut (.mclk, .rst, .actValid, .actCode, .actCond, .scanEnd,
        .hardwareEnableIn, .cmdSourceRef, .keypadRef, .keypadFwd, .keypadRev, .keypadStop,
        .driveEnable, .runFwd, .runRev, .stopCmd, .jogActive, .plcFault, .pidEnable,
        .keypadControl, .refSource, .presetIndex, .speedRef, .tableSwitchEn,
        .activeTableSetting, .commandSourceSelect, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    plcad_ref_model #(.CMD_REF(CMD_REF), .KPD_REF(KPD_REF)) partner (.mclk, .rst,
        .cmdSourceRef, .keypadRef);

    // ==========================================================
    // clock and watchdog; a run needs well under 3000 cycles
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish();
    end

    // ==========================================================
    // bus and scan tasks
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge mclk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        // only the watchdog ends a wait that never sees ack
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'h1);
        rdat = wb_dat_o; // taken at the ack edge only
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i  <= 1'h0;
    endtask
    task automatic act(input logic [5:0] code, input logic cond);
        qCode.push_back(code);
        qCond.push_back(cond);
    endtask
    // an empty queue still ends a scan, so every code reads as unassigned
    task automatic runScan();
        int n;
        n = (qCode.size() == 0) ? 1 : qCode.size();
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            actValid <= (i < qCode.size());
            actCode  <= (i < qCode.size()) ? qCode[i] : 6'h00;
            actCond  <= (i < qCond.size()) ? qCond[i] : 1'h0;
            scanEnd  <= (i == n - 1);
        end
        @(posedge mclk);
        actValid <= 1'h0;
        scanEnd  <= 1'h0;
        qCode.delete();
        qCond.delete();
        repeat (2) @(posedge mclk); // commit edge plus one for the pot path
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {rst, actValid, actCond, scanEnd, hardwareEnableIn, keypadFwd, keypadRev} = '0;
        {keypadStop, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
        {actCode, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        rst = 1'h1;
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        #1;
        `CHECK_EQ(keypadControl, 1'h0)
        `CHECK_EQ(refSource, SRC_COMMAND)
        wbXfer(1'h0, OFS_EPSTEP, 32'h0);
        `CHECK_EQ(rdat, 32'h1)
        wbXfer(1'h0, 8'hfc, 32'h0);
        `CHECK_EQ(rdat, 32'h0)
        wbXfer(1'h1, OFS_JOGSPD, 32'h0123);
        wbXfer(1'h1, OFS_CMDSRC, 32'h2);
        #1;
        `CHECK_EQ(commandSourceSelect, 2'h2)
        for (int i = 0; i < 15; i++) wbXfer(1'h1, OFS_PRESET0 + 8'(4 * i), 32'h1000 + i);
        // enable: hardware input alone, then gated by action 4
        runScan();
        `CHECK_EQ(driveEnable, 1'h0)
        @(posedge mclk);
        hardwareEnableIn <= 1'h1;
        runScan();
        `CHECK_EQ(driveEnable, 1'h1)
        act(ACT_DRIVE_EN, 1'h0);
        runScan();
        `CHECK_EQ(driveEnable, 1'h0)
        act(ACT_DRIVE_EN, 1'h1);
        runScan();
        `CHECK_EQ(driveEnable, 1'h1)
        // jogging, with pid requested to show it is forced off
        act(ACT_JOG_FWD, 1'h1);
        act(ACT_JOG_EN, 1'h1);
        act(ACT_PID, 1'h1);
        runScan();
        `CHECK_EQ({runFwd, runRev, jogActive, speedRef}, {3'h5, 16'h0123})
        `CHECK_EQ(pidEnable, 1'h0)
        act(ACT_JOG_REV, 1'h1);
        act(ACT_JOG_EN, 1'h1);
        runScan();
        `CHECK_EQ({runFwd, runRev, jogActive, speedRef}, {3'h3, 16'h0123})
        act(ACT_JOG_REV, 1'h1);
        act(ACT_JOG_FWD, 1'h1);
        act(ACT_JOG_EN, 1'h1);
        runScan();
        `CHECK_EQ({runFwd, runRev, jogActive, stopCmd}, 4'h1)
        act(ACT_JOG_FWD, 1'h1);
        act(ACT_JOG_EN, 1'h0);
        act(ACT_PID, 1'h1);
        runScan();
        `CHECK_EQ({runFwd, jogActive, pidEnable}, 3'h1)
        act(ACT_STOP, 1'h1);
        act(ACT_FAULT, 1'h1);
        runScan();
        `CHECK_EQ({stopCmd, plcFault}, 2'h3)
        runScan();
        `CHECK_EQ({stopCmd, plcFault, pidEnable}, 3'h0)
        // every preset index value, including the zero-speed code
        for (int k = 0; k < 16; k++) begin
            act(ACT_PRESET, 1'h1);
            for (int b = 0; b < 4; b++) act(ACT_PIDX0 + 6'(b), k[b]);
            runScan();
            `CHECK_EQ(presetIndex, 4'(k))
            `CHECK_EQ(refSource, SRC_PRESET)
            `CHECK_EQ(speedRef, (k == 15) ? 16'h0 : 16'h1000 + 16'(k))
        end
        act(ACT_PRESET, 1'h1);
        runScan();
        `CHECK_EQ({presetIndex, speedRef}, {4'h0, 16'h1000})
        act(ACT_PRESET, 1'h0);
        runScan();
        `CHECK_EQ({refSource, speedRef}, {SRC_COMMAND, CMD_REF})
        // keypad takes over direction and reference
        @(posedge mclk);
        keypadFwd <= 1'h1;
        keypadStop <= 1'h1;
        act(ACT_KEYPAD, 1'h1);
        act(ACT_EPOT, 1'h1);
        act(ACT_PID, 1'h1);
        runScan();
        `CHECK_EQ({keypadControl, runFwd, pidEnable, stopCmd, speedRef}, {4'hd, KPD_REF})
        @(posedge mclk);
        keypadFwd <= 1'h0;
        keypadStop <= 1'h0;
        // electronic pot: step, hold, saturate
        wbXfer(1'h1, OFS_EPSTEP, 32'h10);
        wbXfer(1'h1, OFS_EPOT, 32'h0100);
        act(ACT_EPOT, 1'h1);
        act(ACT_EPOT_UP, 1'h1);
        runScan();
        `CHECK_EQ({refSource, speedRef}, {SRC_EPOT, 16'h0110})
        act(ACT_EPOT, 1'h1);
        act(ACT_EPOT_DN, 1'h1);
        runScan();
        act(ACT_EPOT, 1'h1);
        runScan();
        `CHECK_EQ(speedRef, 16'h0100)
        wbXfer(1'h1, OFS_EPOT, 32'hfff8);
        act(ACT_EPOT, 1'h1);
        act(ACT_EPOT_UP, 1'h1);
        runScan();
        wbXfer(1'h0, OFS_EPOT, 32'h0);
        `CHECK_EQ(rdat, 32'hffff)
        // parameter tables, then switching inhibited
        for (int t = 0; t < 4; t++) begin
            act(ACT_TBL_EN, 1'h1);
            act(ACT_TIDX0, t[0]);
            act(ACT_TIDX1, t[1]);
            runScan();
            `CHECK_EQ({tableSwitchEn, activeTableSetting}, {1'h1, 2'(t)})
        end
        act(ACT_TBL_EN, 1'h0);
        runScan();
        `CHECK_EQ({tableSwitchEn, activeTableSetting}, 3'h3)
        // reserved codes are a configuration fault; each must be flagged
        for (int r = 7; r <= 12; r++) begin
            if (r == 8) continue;
            act(6'(r), 1'h1);
            runScan();
            wbXfer(1'h0, OFS_FLAGS, 32'h0);
            `CHECK_EQ(rdat[0], 1'h1)
            wbXfer(1'h1, OFS_FLAGS, 32'h1);
            wbXfer(1'h0, OFS_FLAGS, 32'h0);
            `CHECK_EQ(rdat[0], 1'h0)
        end
        tally_and_finish();
    end
endmodule // test_plc_action_decoder

bind plcad_action_decoder plcad_action_decoder_properties u_props (.mclk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .scanEnd, .hardwareEnableIn, .driveEnable, .runFwd,
    .runRev, .jogActive, .pidEnable, .plcFault, .keypadControl, .refSource, .presetIndex,
    .tableSwitchEn, .activeTableSetting);
